// ### hw/ovh_tx_port.sv
`timescale 1ns/100ps

module ovh_fifo #(
    parameter int unsigned WIDTH = 7,
    parameter int unsigned DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wr_r;
    logic [AW:0] rd_r;

    wire [AW-1:0] wr_idx = wr_r[AW-1:0];
    wire [AW-1:0] rd_idx = rd_r[AW-1:0];
    // Extra pointer bit tells full from empty when the indices match
    wire idx_same = (wr_idx == rd_idx);
    wire full = (wr_r[AW] != rd_r[AW]) && idx_same;
    wire empty = (wr_r == rd_r);
    wire push = in_valid_i && !full;
    wire pop = out_valid_o && out_ready_i;

    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem_r[rd_idx];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_r <= '0;
        end else if (push) begin
            wr_r <= wr_r + {{AW{1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_r <= '0;
        end else if (pop) begin
            rd_r <= rd_r + {{AW{1'b0}}, 1'b1};
        end
    end

    // Storage carries no reset: only the pointers decide what is valid
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wr_idx] <= in_data_i;
        end
    end
endmodule

module ovh_tx_port import ovh_pkg::*; #(
    parameter int unsigned FIFO_DEPTH = OVH_FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ovh_insert_request_i,
    input wire logic ovh_serial_in_i,
    input wire logic payload_i,
    input wire logic int_ovh_i,
    output logic ovh_slot_strobe_o,
    output logic ovh_frame_boundary_o,
    output logic tx_data_o,
    output logic tx_ovh_mark_o,
    output logic ins_drop_o
);
    logic [6:0] blk_r;
    logic [5:0] slot_r;
    logic strobe_r;
    logic frame_r;
    logic tx_data_r;
    logic tx_ovh_r;
    logic drop_r;
    logic cap_vld_r;
    logic cap_dat_r;
    logic [5:0] cap_slot_r;
    logic [OVH_SLOTS-1:0] pend_vld_r;
    logic [OVH_SLOTS-1:0] pend_val_r;
    logic [OVH_SLOTS-1:0] act_vld_r;
    logic [OVH_SLOTS-1:0] act_val_r;
    logic [OVH_SLOTS-1:0] pend_vld_nxt;
    logic [OVH_SLOTS-1:0] pend_val_nxt;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [OVH_FIFO_WIDTH-1:0] fifo_out_data;
    logic [OVH_FIFO_WIDTH-1:0] cap_word;
    // One-hot walk through each block: overhead bit, payload run, strobe cycle
    typedef enum logic [2:0] {
        PH_OVH = 3'h1,
        PH_PAY = 3'h2,
        PH_STB = 3'h4
    } ovh_phase_t;
    ovh_phase_t ph_r;
    ovh_phase_t ph_nxt;

    // Bit position within the block and overhead slot within the frame
    wire at_oh = (ph_r == PH_OVH);
    wire at_blk_end = (blk_r == OVH_BLK_LAST);
    wire slot_last = (slot_r == OVH_SLOT_LAST);
    wire at_frame_end = at_blk_end && slot_last;
    wire [6:0] blk_nxt = at_blk_end ? OVH_BLK_OH_POS : blk_r + 7'h01;
    wire [5:0] slot_inc = slot_last ? OVH_SLOT_RST : slot_r + 6'h01;
    wire [5:0] slot_nxt = at_blk_end ? slot_inc : slot_r;
    wire strobe_nxt = (ph_nxt == PH_STB);

    always_comb begin
        ph_nxt = ph_r;
        case (ph_r)
            PH_OVH: begin
                ph_nxt = PH_PAY;
            end
            PH_PAY: begin
                if (blk_nxt == OVH_BLK_LAST) begin
                    ph_nxt = PH_STB;
                end
            end
            PH_STB: begin
                ph_nxt = PH_OVH;
            end
            default: begin
                ph_nxt = PH_OVH;
            end
        endcase
    end
    wire frame_nxt = strobe_nxt && (slot_nxt == OVH_SLOT_LAST);

    // Only insertable slots are accepted, and only with the request high
    wire slot_insertable = OVH_INSERT_MASK[slot_r];
    wire req_at_oh = ovh_insert_request_i && at_oh;
    wire take_ins = req_at_oh && slot_insertable;

    // Pops stall in the swap cycle so no write lands on a half-copied frame
    // Slot 55 is never insertable, so the stall there loses nothing
    wire drain_ready = !at_frame_end;
    wire pop = fifo_out_valid && drain_ready;
    wire [5:0] pop_slot = fifo_out_data[OVH_FIFO_WIDTH-1:1];
    wire pop_dat = fifo_out_data[0];

    // Outbound bit: replaced slot value, else internal overhead, else payload
    wire ovh_sel = act_vld_r[slot_r];
    wire ovh_bit = ovh_sel ? act_val_r[slot_r] : int_ovh_i;
    wire tx_data_nxt = at_oh ? ovh_bit : payload_i;
    wire drop_nxt = cap_vld_r && !fifo_in_ready;

    genvar gi;
    generate
        for (gi = 0; gi < OVH_SLOTS; gi = gi + 1) begin : g_slot
            wire hit = pop && (pop_slot == OVH_SLOT_W'(gi));
            assign pend_vld_nxt[gi] = at_frame_end ? 1'b0 : (pend_vld_r[gi] | hit);
            assign pend_val_nxt[gi] = hit ? pop_dat : pend_val_r[gi];
        end
    endgenerate

    // Counters free-run from reset; the terminal syncs on the first strobe with boundary
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ph_r <= PH_OVH;
        end else begin
            ph_r <= ph_nxt;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            blk_r <= OVH_BLK_RST;
        end else begin
            blk_r <= blk_nxt;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            slot_r <= OVH_SLOT_RST;
        end else begin
            slot_r <= slot_nxt;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strobe_r <= 1'b0;
        end else begin
            strobe_r <= strobe_nxt;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frame_r <= 1'b0;
        end else begin
            frame_r <= frame_nxt;
        end
    end

    // Falling-edge capture gives the terminal half a cycle after its rising-edge drive
    // Request and data must stand from the rising edge through this falling edge
    always_ff @(negedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cap_vld_r <= 1'b0;
        end else begin
            cap_vld_r <= take_ins;
        end
    end

    always_ff @(negedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cap_dat_r <= 1'b0;
            cap_slot_r <= OVH_SLOT_RST;
        end else if (take_ins) begin
            cap_dat_r <= ovh_serial_in_i;
            cap_slot_r <= slot_r;
        end
    end

    // Pending slots gather this frame's insertions; they go live at the frame end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_vld_r <= '0;
            pend_val_r <= '0;
        end else begin
            pend_vld_r <= pend_vld_nxt;
            pend_val_r <= pend_val_nxt;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            act_vld_r <= '0;
            act_val_r <= '0;
        end else if (at_frame_end) begin
            act_vld_r <= pend_vld_r;
            act_val_r <= pend_val_r;
        end
    end

    // The outbound bit is registered, so it trails its position by one cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_data_r <= 1'b0;
        end else begin
            tx_data_r <= tx_data_nxt;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_ovh_r <= 1'b0;
        end else begin
            tx_ovh_r <= at_oh;
        end
    end

    // At one insertion per 85 cycles the FIFO cannot fill; the pulse flags it anyway
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drop_r <= 1'b0;
        end else begin
            drop_r <= drop_nxt;
        end
    end

    // Slot number travels with the bit so the pop side needs no counter of its own
    assign cap_word = {cap_slot_r, cap_dat_r};

    ovh_fifo #(
        .WIDTH(OVH_FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(cap_vld_r),
        .in_ready_o(fifo_in_ready),
        .in_data_i(cap_word),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(drain_ready),
        .out_data_o(fifo_out_data)
    );

    assign ovh_slot_strobe_o = strobe_r;
    assign ovh_frame_boundary_o = frame_r;
    assign tx_data_o = tx_data_r;
    assign tx_ovh_mark_o = tx_ovh_r;
    assign ins_drop_o = drop_r;
endmodule

// ### include/ovh_pkg.sv
package ovh_pkg;
    // Bits per block: one overhead bit followed by 84 payload bits
    localparam int unsigned OVH_BLK_BITS = 85;
    localparam logic [6:0] OVH_BLK_OH_POS = 7'h00;
    localparam logic [6:0] OVH_BLK_LAST = 7'h54;
    localparam logic [6:0] OVH_BLK_RST = 7'h00;
    // Overhead slots per frame, counted from the coincident strobe and boundary
    localparam int unsigned OVH_SLOTS = 56;
    localparam int unsigned OVH_SLOT_W = 6;
    localparam logic [5:0] OVH_SLOT_LAST = 6'h37;
    localparam logic [5:0] OVH_SLOT_RST = 6'h00;
    // One bit per slot: X, AIC, NA, FEAC, UDL, CP, FEBE and DL positions accept insertion
    localparam logic [55:0] OVH_INSERT_MASK = 56'h54_5454_5454_5555;
    localparam int unsigned OVH_FIFO_DEPTH = 8;
    localparam int unsigned OVH_FIFO_WIDTH = OVH_SLOT_W + 1;
endpackage

// ### sim/ovh_term_model.sv
`timescale 1ns/100ps
module ovh_term_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic strobe_i,
    input wire logic boundary_i,
    input wire logic [55:0] map_i,
    input wire logic [55:0] bits_i,
    output logic req_o,
    output logic ser_o
);
    logic [5:0] slot_r;
    logic [55:0] map_r, bits_r;
    logic sync_r;
    // Plan is latched at frame start so the bench may change it freely mid-frame
    wire start_w = strobe_i && boundary_i;
    wire [5:0] slot_w = start_w ? 6'h00 : slot_r + 6'h01;
    wire [55:0] map_w = start_w ? map_i : map_r;
    wire [55:0] bits_w = start_w ? bits_i : bits_r;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {slot_r, map_r, bits_r, sync_r, req_o, ser_o} <= '0;
        end else begin
            req_o <= 1'b0;
            // Released line toggles so a stale bit cannot pass for a captured one
            ser_o <= ~ser_o;
            if (strobe_i) begin
                {slot_r, map_r, bits_r} <= {slot_w, map_w, bits_w};
                sync_r <= sync_r | start_w;
                if ((sync_r || start_w) && map_w[slot_w]) begin
                    req_o <= 1'b1;
                    ser_o <= bits_w[slot_w];
                end
            end
        end
    end
endmodule

// ### sim/ovh_tx_port_checker.sv
`timescale 1ns/100ps
module ovh_tx_port_checker import ovh_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ovh_insert_request_i,
    input wire logic ovh_slot_strobe_o,
    input wire logic ovh_frame_boundary_o,
    input wire logic tx_ovh_mark_o,
    input wire logic ins_drop_o
);
    wire stb = ovh_slot_strobe_o;
    wire bnd = ovh_frame_boundary_o;
    wire mrk = tx_ovh_mark_o;
    logic [5:0] n_r;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Strobes since the last boundary; the boundary must land on the 56th
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            n_r <= 6'h00;
        end else if (stb) begin
            n_r <= bnd ? 6'h00 : n_r + 6'h01;
        end
    end
    a_strobe_period: assert property (stb |-> ##85 stb) else $error("strobe period");
    a_strobe_gap: assert property (stb |=> !stb [*8]) else $error("strobe too long");
    a_mark_after: assert property (stb |-> ##2 mrk) else $error("no overhead bit");
    a_mark_single: assert property (mrk |=> !mrk) else $error("mark too long");
    a_bound_strobe: assert property (bnd |-> stb) else $error("lone boundary");
    a_bound_gap: assert property (bnd |=> !bnd [*8]) else $error("boundary too long");
    a_frame_slots: assert property (stb |-> bnd == (n_r == OVH_SLOT_LAST)) else $error("frame length");
    a_no_drop: assert property (!ins_drop_o) else $error("insertion lost");
    c_frame: cover property (bnd);
    c_insert: cover property (stb ##1 ovh_insert_request_i);
    c_mark: cover property (mrk);
endmodule

// ### sim/test_ovh_tx_port.sv
`timescale 1ns/100ps
module test_ovh_tx_port import ovh_pkg::*; ;
    localparam logic [55:0] P1 = 56'hc3_a55a_0ff0_3c96;
    localparam logic [55:0] M = OVH_INSERT_MASK;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic payload_i = 1'b0;
    logic int_ovh_i = 1'b0;
    logic [7:0] cyc = 8'h00;
    logic [55:0] map = ~M;
    logic [55:0] bits = P1;
    logic req, ser, strobe, bound, tx_data, mark;
    int n_errors = 0;
    int n_checks = 0;
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 8'h01;
        payload_i <= cyc[0];
        int_ovh_i <= cyc[1] ^ cyc[4];
    end
    ovh_tx_port dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ovh_insert_request_i(req), .ovh_serial_in_i(ser),
        .payload_i(payload_i), .int_ovh_i(int_ovh_i), .ovh_slot_strobe_o(strobe),
        .ovh_frame_boundary_o(bound), .tx_data_o(tx_data), .tx_ovh_mark_o(mark), .ins_drop_o());
    ovh_term_model term (.clk_i(clk_i), .rst_n_i(rst_n_i), .strobe_i(strobe), .boundary_i(bound),
        .map_i(map), .bits_i(bits), .req_o(req), .ser_o(ser));
    task automatic cmp(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %b, seen %b", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Checks a frame against the plan armed two frames earlier, and arms the model for the next
    task automatic check_frame(input logic [55:0] ins, val, nm, nb);
        logic iv;
        int w;
        for (int s = 0; s < OVH_SLOTS; s++) begin
            w = 0;
            do begin
                @(posedge clk_i);
                #1;
                w++;
            end while (!(strobe === 1'b1 && (s > 0 || bound === 1'b1)) && w < 5000);
            if (w >= 5000) n_errors++;
            cmp("boundary", s == 0, bound);
            @(posedge clk_i);
            if (s == 0) begin
                map <= nm;
                bits <= nb;
            end
            #1;
            iv = int_ovh_i;
            @(posedge clk_i);
            #1;
            cmp("mark", 1'b1, mark);
            cmp("bit", ins[s] ? val[s] : iv, tx_data);
        end
    endtask
    task automatic s_refused_frame();
        check_frame(56'h0, 56'h0, M, P1);
        check_frame(56'h0, 56'h0, M, ~P1);
    endtask
    task automatic s_insert_frame();
        check_frame(M, P1, 56'h0, 56'h0);
        check_frame(M, ~P1, 56'h0, 56'h0);
    endtask
    task automatic s_cleared_frame();
        check_frame(56'h0, 56'h0, 56'h0, 56'h0);
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        s_refused_frame();
        s_insert_frame();
        s_cleared_frame();
        give_verdict();
    end
    initial begin
        #200000;
        n_errors++;
        give_verdict();
    end
endmodule
bind ovh_tx_port ovh_tx_port_checker chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .ovh_insert_request_i(ovh_insert_request_i), .ovh_slot_strobe_o(ovh_slot_strobe_o),
    .ovh_frame_boundary_o(ovh_frame_boundary_o), .tx_ovh_mark_o(tx_ovh_mark_o), .ins_drop_o(ins_drop_o));
